/* File: axis_motion_pkg.sv */
// Shared constants for the per-axis encoder, command and watchdog logic.
// Assumes a single system clock at the rate named below.
package axis_motion_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int NUM_AXES = 4;
    localparam int POS_W = 32;
    localparam int DAC_W = 16;
    localparam int SYNC_STAGES = 3;
    // Watchdog timeout in microseconds and derived cycles
    localparam int WDOG_TIMEOUT_US = 1000;
    localparam int WDOG_CYCLES = (WDOG_TIMEOUT_US * (CLK_HZ / 1_000_000));
    // Step pulse high time in nanoseconds and derived cycles (at least one)
    localparam int STEP_PULSE_NS = 200;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int STEP_PULSE_CYC_RAW = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_PULSE_CYC = (STEP_PULSE_CYC_RAW < 1) ? 1 : STEP_PULSE_CYC_RAW;
    localparam logic [15:0] DAC_MID = 16'h8000;
    localparam logic [1:0] MODE_SERVO = 2'h0;
    localparam logic [1:0] MODE_SINE = 2'h1;
    localparam logic [1:0] MODE_STEP = 2'h2;
endpackage

/* File: axis_motion_if.sv */
// Per-axis encoder decode, position capture and motor command outputs; one watchdog shared by all axes.
// Assumes pins are asynchronous and the processor drives the command inputs
// synchronously on CLK_SYS_IN.
`timescale 1ns/10ps
`default_nettype none
module axis_motion_if
    import axis_motion_pkg::*;
#(
    parameter int AXES = NUM_AXES,
    parameter int WDOG_TIMEOUT = WDOG_CYCLES
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // Encoder pins: index 0..AXES-1 main, AXES..2*AXES-1 auxiliary
    input wire logic [2*AXES-1:0] ENCODER_PHASE_A_IN,
    input wire logic [2*AXES-1:0] ENCODER_PHASE_B_IN,
    input wire logic [2*AXES-1:0] ENCODER_INDEX_IN,
    input wire logic [2*AXES-1:0] PULSE_DIR_FB_IN,
    input wire logic [AXES-1:0] GEN_TRIGGER_IN,
    input wire logic [AXES-1:0] LATCH_ARM_IN,
    input wire logic [2*AXES-1:0] AXIS_MODE_IN,
    input wire logic [AXES-1:0] AUX_UNUSED_IN,
    input wire logic [AXES*DAC_W-1:0] CMD_MAIN_IN,
    input wire logic [AXES*DAC_W-1:0] CMD_SINE_IN,
    input wire logic [AXES-1:0] STEP_REQ_IN,
    input wire logic [AXES-1:0] STEP_DIR_IN,
    input wire logic WDOG_KICK_IN,
    output logic [2*AXES*POS_W-1:0] POSITION_OUT,
    output logic [2*AXES-1:0] INDEX_SEEN_OUT,
    output logic [AXES*POS_W-1:0] LATCHED_POS_OUT,
    output logic [AXES-1:0] LATCH_DONE_OUT,
    output logic [2*AXES-1:0] AUX_GP_IN_OUT,
    output logic [AXES*DAC_W-1:0] DAC_A_OUT,
    output logic [AXES*DAC_W-1:0] DAC_B_OUT,
    output logic [AXES-1:0] STEP_OUT,
    output logic [AXES-1:0] DIR_OUT,
    output logic AMP_ENABLE_OUT,
    output logic [AXES-1:0] ERROR_LED_OUT
);
    localparam int ENC = 2 * AXES;
    localparam int PIN_W = 4 * ENC + AXES;

    // Convert signed command to offset-binary converter code
    function automatic logic [DAC_W-1:0] to_dac(input logic [DAC_W-1:0] cmd);
        return cmd ^ DAC_MID;
    endfunction

    // Three-stage synchronisers for every asynchronous pin
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] s1_r, s2_r, s3_r, stable_r;
    logic [PIN_W-1:0] s1_nxt, s2_nxt, s3_nxt, stable_nxt;
    assign pins_raw = {GEN_TRIGGER_IN, PULSE_DIR_FB_IN, ENCODER_INDEX_IN,
                       ENCODER_PHASE_B_IN, ENCODER_PHASE_A_IN};
    always_comb begin
        s1_nxt = pins_raw;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        stable_nxt = stable_r;
        for (int i = 0; i < PIN_W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                stable_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            stable_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            stable_r <= stable_nxt;
        end
    end

    logic [ENC-1:0] pha, phb, idx, pdir;
    logic [AXES-1:0] trig;
    assign pha = stable_r[ENC-1:0];
    assign phb = stable_r[2*ENC-1:ENC];
    assign idx = stable_r[3*ENC-1:2*ENC];
    assign pdir = stable_r[4*ENC-1:3*ENC];
    assign trig = stable_r[PIN_W-1:4*ENC];

    // Encoder decoders, one per main and auxiliary encoder
    logic [ENC-1:0] pa_r, pb_r, pi_r, idx_seen_r, pa_nxt, pb_nxt, pi_nxt, idx_seen_nxt;
    logic [POS_W-1:0] pos_r [ENC];
    logic [POS_W-1:0] pos_nxt [ENC];
    logic [ENC-1:0] gp_r, gp_nxt;
    always_comb begin
        pa_nxt = pha;
        pb_nxt = phb;
        pi_nxt = idx;
        idx_seen_nxt = idx_seen_r;
        gp_nxt = gp_r;
        for (int e = 0; e < ENC; e++) begin
            pos_nxt[e] = pos_r[e];
            if (idx[e] && !pi_r[e]) begin
                idx_seen_nxt[e] = 1'b1;
            end
            if (AXIS_MODE_IN[2*(e%AXES)+:2] == MODE_STEP) begin
                if (pha[e] && !pa_r[e]) begin
                    pos_nxt[e] = pdir[e] ? pos_r[e] - 1'b1 : pos_r[e] + 1'b1;
                end
            end else if ((pha[e] ^ pa_r[e]) && !(phb[e] ^ pb_r[e])) begin
                pos_nxt[e] = (pha[e] ^ phb[e]) ? pos_r[e] + 1'b1 : pos_r[e] - 1'b1;
            end else if ((phb[e] ^ pb_r[e]) && !(pha[e] ^ pa_r[e])) begin
                pos_nxt[e] = (pha[e] ^ phb[e]) ? pos_r[e] - 1'b1 : pos_r[e] + 1'b1;
            end
        end
        for (int a = 0; a < AXES; a++) begin
            if (AUX_UNUSED_IN[a] && AXIS_MODE_IN[2*a+:2] != MODE_STEP) begin
                gp_nxt[2*a] = pha[AXES+a];
                gp_nxt[2*a+1] = phb[AXES+a];
            end else begin
                gp_nxt[2*a+:2] = 2'h0;
            end
        end
    end
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pa_r <= '0;
            pb_r <= '0;
            pi_r <= '0;
            idx_seen_r <= '0;
            gp_r <= '0;
            for (int e = 0; e < ENC; e++) begin
                pos_r[e] <= '0;
            end
        end else begin
            pa_r <= pa_nxt;
            pb_r <= pb_nxt;
            pi_r <= pi_nxt;
            idx_seen_r <= idx_seen_nxt;
            gp_r <= gp_nxt;
            for (int e = 0; e < ENC; e++) begin
                pos_r[e] <= pos_nxt[e];
            end
        end
    end

    // Position latch, command outputs and step pulses
    logic [AXES-1:0] ptrig_r, armed_r, done_r, ptrig_nxt, armed_nxt, done_nxt;
    logic [POS_W-1:0] lat_r [AXES];
    logic [POS_W-1:0] lat_nxt [AXES];
    logic [AXES*DAC_W-1:0] dac_a_r, dac_b_r, dac_a_nxt, dac_b_nxt;
    logic [AXES-1:0] step_r, dir_r, step_nxt, dir_nxt;
    logic [7:0] step_cnt_r [AXES];
    logic [7:0] step_cnt_nxt [AXES];
    always_comb begin
        ptrig_nxt = trig;
        armed_nxt = armed_r;
        done_nxt = done_r;
        dac_a_nxt = dac_a_r;
        dac_b_nxt = dac_b_r;
        step_nxt = step_r;
        dir_nxt = dir_r;
        for (int a = 0; a < AXES; a++) begin
            lat_nxt[a] = lat_r[a];
            step_cnt_nxt[a] = step_cnt_r[a];
            if (LATCH_ARM_IN[a]) begin
                armed_nxt[a] = 1'b1;
                done_nxt[a] = 1'b0;
            end
            if (armed_r[a] && trig[a] && !ptrig_r[a]) begin
                lat_nxt[a] = pos_r[a];
                armed_nxt[a] = 1'b0;
                done_nxt[a] = 1'b1;
            end
            dac_a_nxt[a*DAC_W+:DAC_W] = DAC_MID;
            dac_b_nxt[a*DAC_W+:DAC_W] = DAC_MID;
            case (AXIS_MODE_IN[2*a+:2])
                MODE_SERVO: begin
                    dac_a_nxt[a*DAC_W+:DAC_W] = to_dac(CMD_MAIN_IN[a*DAC_W+:DAC_W]);
                end
                MODE_SINE: begin
                    dac_a_nxt[a*DAC_W+:DAC_W] = to_dac(CMD_MAIN_IN[a*DAC_W+:DAC_W]);
                    dac_b_nxt[a*DAC_W+:DAC_W] = to_dac(CMD_SINE_IN[a*DAC_W+:DAC_W]);
                end
                default: begin
                end
            endcase
            if (AXIS_MODE_IN[2*a+:2] == MODE_STEP) begin
                if (step_cnt_r[a] != 8'h00) begin
                    step_cnt_nxt[a] = step_cnt_r[a] - 8'h01;
                    step_nxt[a] = (step_cnt_r[a] != 8'h01);
                end else if (STEP_REQ_IN[a]) begin
                    dir_nxt[a] = STEP_DIR_IN[a];
                    step_nxt[a] = 1'b1;
                    step_cnt_nxt[a] = 8'(STEP_PULSE_CYC);
                end
            end else begin
                step_nxt[a] = 1'b0;
                step_cnt_nxt[a] = 8'h00;
            end
        end
    end
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ptrig_r <= '0;
            armed_r <= '0;
            done_r <= '0;
            dac_a_r <= {AXES{DAC_MID}};
            dac_b_r <= {AXES{DAC_MID}};
            step_r <= '0;
            dir_r <= '0;
            for (int a = 0; a < AXES; a++) begin
                lat_r[a] <= '0;
                step_cnt_r[a] <= 8'h00;
            end
        end else begin
            ptrig_r <= ptrig_nxt;
            armed_r <= armed_nxt;
            done_r <= done_nxt;
            dac_a_r <= dac_a_nxt;
            dac_b_r <= dac_b_nxt;
            step_r <= step_nxt;
            dir_r <= dir_nxt;
            for (int a = 0; a < AXES; a++) begin
                lat_r[a] <= lat_nxt[a];
                step_cnt_r[a] <= step_cnt_nxt[a];
            end
        end
    end

    // Watchdog: one-hot states
    typedef enum logic [2:0] {
        WD_POWERUP = 3'b001,
        WD_RUN = 3'b010,
        WD_FAILED = 3'b100
    } wd_state_t;
    wd_state_t wd_r, wd_nxt;
    logic [31:0] wd_cnt_r, wd_cnt_nxt;
    logic amp_r, amp_nxt;
    logic [AXES-1:0] err_r, err_nxt;
    always_comb begin
        wd_nxt = wd_r;
        wd_cnt_nxt = wd_cnt_r;
        case (wd_r)
            WD_POWERUP: begin
                if (WDOG_KICK_IN) begin
                    wd_nxt = WD_RUN;
                    wd_cnt_nxt = '0;
                end
            end
            WD_RUN: begin
                if (WDOG_KICK_IN) begin
                    wd_cnt_nxt = '0;
                end else if (wd_cnt_r >= 32'(WDOG_TIMEOUT - 1)) begin
                    wd_nxt = WD_FAILED;
                end else begin
                    wd_cnt_nxt = wd_cnt_r + 32'h1;
                end
            end
            WD_FAILED: begin
                wd_nxt = WD_FAILED;
            end
            default: begin
                wd_nxt = WD_FAILED;
            end
        endcase
        amp_nxt = (wd_nxt == WD_RUN);
        err_nxt = (wd_nxt == WD_RUN) ? '0 : '1;
    end
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wd_r <= WD_POWERUP;
            wd_cnt_r <= '0;
            amp_r <= 1'b0;
            err_r <= '1;
        end else begin
            wd_r <= wd_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            amp_r <= amp_nxt;
            err_r <= err_nxt;
        end
    end

    // No feedback-loss check on any axis
    always_comb begin
        for (int e = 0; e < ENC; e++) begin
            POSITION_OUT[e*POS_W+:POS_W] = pos_r[e];
        end
        for (int a = 0; a < AXES; a++) begin
            LATCHED_POS_OUT[a*POS_W+:POS_W] = lat_r[a];
        end
    end
    assign INDEX_SEEN_OUT = idx_seen_r;
    assign LATCH_DONE_OUT = done_r;
    assign AUX_GP_IN_OUT = gp_r;
    assign DAC_A_OUT = dac_a_r;
    assign DAC_B_OUT = dac_b_r;
    assign STEP_OUT = step_r;
    assign DIR_OUT = dir_r;
    assign AMP_ENABLE_OUT = amp_r;
    assign ERROR_LED_OUT = err_r;
endmodule
`default_nettype wire

/* File: axis_motion_props.sv */
// Checker for the axis motion block, watching axis 0 at the top ports.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module axis_motion_props
    import axis_motion_pkg::*;
#(
    parameter int AXES = NUM_AXES,
    parameter int WDOG_TIMEOUT = WDOG_CYCLES
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic [2*AXES-1:0] AXIS_MODE_IN,
    input wire logic [AXES-1:0] AUX_UNUSED_IN,
    input wire logic [AXES*DAC_W-1:0] CMD_MAIN_IN,
    input wire logic [AXES-1:0] STEP_REQ_IN,
    input wire logic WDOG_KICK_IN,
    input wire logic [2*AXES*POS_W-1:0] POSITION_OUT,
    input wire logic [AXES-1:0] LATCH_DONE_OUT,
    input wire logic [2*AXES-1:0] AUX_GP_IN_OUT,
    input wire logic [AXES*DAC_W-1:0] DAC_A_OUT,
    input wire logic [AXES*DAC_W-1:0] DAC_B_OUT,
    input wire logic [AXES-1:0] STEP_OUT,
    input wire logic AMP_ENABLE_OUT,
    input wire logic [AXES-1:0] ERROR_LED_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    a_amp_needs_kick: assert property ($rose(AMP_ENABLE_OUT) |-> $past(WDOG_KICK_IN))
        else $error("amplifier enabled without a kick");
    a_leds_track_amp: assert property (ERROR_LED_OUT == {AXES{!AMP_ENABLE_OUT}})
        else $error("error lights disagree with amplifier enable");
    a_fail_holds: assert property ($fell(AMP_ENABLE_OUT) |-> !AMP_ENABLE_OUT [*8])
        else $error("amplifier re-enabled after trip");
    // Sticky record of a trip, cleared only by reset
    logic amp_q_r, tripped_r;
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            amp_q_r <= 1'b0;
            tripped_r <= 1'b0;
        end else begin
            amp_q_r <= AMP_ENABLE_OUT;
            if (amp_q_r && !AMP_ENABLE_OUT) begin
                tripped_r <= 1'b1;
            end
        end
    end
    a_trip_latched: assert property (tripped_r |-> !AMP_ENABLE_OUT)
        else $error("amplifier enabled after trip before reset");
    a_step_width: assert property ($rose(STEP_OUT[0]) |-> STEP_OUT[0] [*2] ##1 !STEP_OUT[0])
        else $error("step pulse width wrong");
    a_step_cause: assert property ($rose(STEP_OUT[0]) |-> $past(STEP_REQ_IN[0]) && $past(AXIS_MODE_IN[1:0]) == MODE_STEP)
        else $error("step pulse without stepper request");
    a_dacb_mid: assert property (AXIS_MODE_IN[1:0] != MODE_SINE |=> DAC_B_OUT[15:0] == DAC_MID)
        else $error("second converter active outside sine mode");
    a_daca_servo: assert property (AXIS_MODE_IN[1:0] == MODE_SERVO |=> DAC_A_OUT[15:0] == ($past(CMD_MAIN_IN[15:0]) ^ DAC_MID))
        else $error("servo converter code wrong");
    a_aux_gp_zero: assert property ((!AUX_UNUSED_IN[0] || AXIS_MODE_IN[1:0] == MODE_STEP) [*2] |-> AUX_GP_IN_OUT[1:0] == 2'h0)
        else $error("aux general inputs shown while aux in use");
    a_pos_unit: assert property ($changed(POSITION_OUT[31:0]) |-> (POSITION_OUT[31:0] - $past(POSITION_OUT[31:0])) inside {32'h1, 32'hffffffff})
        else $error("position moved by more than one count");
    cover property ($fell(AMP_ENABLE_OUT));
    cover property ($rose(STEP_OUT[0]));
    cover property ($rose(LATCH_DONE_OUT[0]));
endmodule
bind axis_motion_if axis_motion_props #(.AXES(AXES), .WDOG_TIMEOUT(WDOG_TIMEOUT)) u_axis_motion_props (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .AXIS_MODE_IN(AXIS_MODE_IN), .AUX_UNUSED_IN(AUX_UNUSED_IN),
    .CMD_MAIN_IN(CMD_MAIN_IN), .STEP_REQ_IN(STEP_REQ_IN), .WDOG_KICK_IN(WDOG_KICK_IN), .POSITION_OUT(POSITION_OUT),
    .LATCH_DONE_OUT(LATCH_DONE_OUT), .AUX_GP_IN_OUT(AUX_GP_IN_OUT), .DAC_A_OUT(DAC_A_OUT), .DAC_B_OUT(DAC_B_OUT),
    .STEP_OUT(STEP_OUT), .AMP_ENABLE_OUT(AMP_ENABLE_OUT), .ERROR_LED_OUT(ERROR_LED_OUT));
`default_nettype wire

/* File: quad_encoder_model.sv */
// Quadrature encoder on the motor shaft, one state per move request.
// Assumes the bench spaces requests so the phase rate stays legal.
`timescale 1ns/10ps
`default_nettype none
module quad_encoder_model (
    input wire logic clk_in,
    input wire logic move_in,
    input wire logic dir_in,
    output logic phase_a_out,
    output logic phase_b_out
);
    logic [1:0] state_r = 2'h0;
    always @(posedge clk_in) begin
        if (move_in) begin
            state_r <= dir_in ? state_r - 2'h1 : state_r + 2'h1;
        end
    end
    assign phase_a_out = state_r[1] ^ state_r[0];
    assign phase_b_out = state_r[1];
endmodule
`default_nettype wire

/* File: test_axis_motion_if.sv */
// Self-checking bench for the axis motion block with one axis.
// Assumes the encoder model above and a short watchdog timeout.
`timescale 1ns/10ps
`default_nettype none
module test_axis_motion_if import axis_motion_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] idx, pdir, mode, gp, iseen;
    logic trig, arm, aux_un, req, sdir, kick, mv, mdir, pd_sel, pd_a, aux_a, aux_b;
    logic ldone, so, dout, amp, led;
    logic [15:0] cm, cs, da, db;
    logic [63:0] pos;
    logic [31:0] lpos;
    wire logic qa, qb;
    int bad_count, check_count, cyc, exp_pos;

    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end

    quad_encoder_model u_quad_encoder_model (.clk_in(clk), .move_in(mv), .dir_in(mdir),
        .phase_a_out(qa), .phase_b_out(qb));
    axis_motion_if #(.AXES(1), .WDOG_TIMEOUT(16)) u_axis_motion_if (
        .CLK_SYS_IN(clk), .RST_IN(rst), .ENCODER_PHASE_A_IN({aux_a, pd_sel ? pd_a : qa}),
        .ENCODER_PHASE_B_IN({aux_b, qb}), .ENCODER_INDEX_IN(idx), .PULSE_DIR_FB_IN(pdir),
        .GEN_TRIGGER_IN(trig), .LATCH_ARM_IN(arm), .AXIS_MODE_IN(mode), .AUX_UNUSED_IN(aux_un),
        .CMD_MAIN_IN(cm), .CMD_SINE_IN(cs), .STEP_REQ_IN(req), .STEP_DIR_IN(sdir), .WDOG_KICK_IN(kick),
        .POSITION_OUT(pos), .INDEX_SEEN_OUT(iseen), .LATCHED_POS_OUT(lpos), .LATCH_DONE_OUT(ldone),
        .AUX_GP_IN_OUT(gp), .DAC_A_OUT(da), .DAC_B_OUT(db), .STEP_OUT(so), .DIR_OUT(dout),
        .AMP_ENABLE_OUT(amp), .ERROR_LED_OUT(led));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [15:0] dac_exp(input logic [1:0] m, input logic [15:0] c, input logic side_b);
        if (side_b ? m != MODE_SINE : m == MODE_STEP) return DAC_MID;
        return c ^ DAC_MID;
    endfunction
    task automatic results;
        if (bad_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        {idx, pdir, trig, arm, aux_un, req, sdir, kick, mv, mdir, pd_sel, pd_a, aux_a, aux_b, cm, cs} = '0;
        mode = MODE_SERVO;
        void'($urandom(32'h186f0e06));
        w(20);
        rst = 1'b0;
        w(1);
        chk("amp", 0, amp);
        chk("led", 1, led);
        chk("daca", DAC_MID, da);
        kick = 1'b1;
        w(3);
        chk("amp", 1, amp);
        for (int i = 0; i < 40; i++) begin
            mdir = 1'($urandom);
            mv = 1'b1;
            w(1);
            mv = 1'b0;
            w(3);
            exp_pos += mdir ? -1 : 1;
        end
        w(8);
        chk("pos", exp_pos, pos[31:0]);
        // Both aux phases flip in one step
        aux_un = 1'b1;
        aux_a = 1'b1;
        aux_b = 1'b1;
        w(8);
        chk("auxpos", 0, pos[63:32]);
        chk("gp", 3, gp);
        // Aux decoder steps back on its own, main count stays put
        aux_b = 1'b0;
        w(8);
        chk("auxpos", 32'hffffffff, pos[63:32]);
        chk("pos", exp_pos, pos[31:0]);
        chk("gp", 1, gp);
        mode = MODE_STEP;
        w(3);
        chk("gp", 0, gp);
        mode = MODE_SERVO;
        arm = 1'b1;
        w(1);
        arm = 1'b0;
        w(2);
        trig = 1'b1;
        w(8);
        chk("done", 1, ldone);
        chk("lpos", exp_pos, lpos);
        for (int i = 0; i < 12; i++) begin
            mode = 2'(i % 3);
            cm = 16'($urandom);
            cs = 16'($urandom);
            w(2);
            chk("daca", dac_exp(mode, cm, 1'b0), da);
            chk("dacb", dac_exp(mode, cs, 1'b1), db);
        end
        kick = 1'b0;
        w(24);
        chk("amp", 0, amp);
        chk("led", 1, led);
        kick = 1'b1;
        w(5);
        chk("amp", 0, amp);
        mode = MODE_STEP;
        pd_sel = 1'b1;
        rst = 1'b1;
        w(20);
        rst = 1'b0;
        w(3);
        exp_pos = 0;
        for (int i = 0; i < 10; i++) begin
            pdir[0] = 1'($urandom);
            pd_a = 1'b1;
            w(4);
            pd_a = 1'b0;
            w(4);
            exp_pos += pdir[0] ? -1 : 1;
        end
        chk("pos", exp_pos, pos[31:0]);
        chk("amp", 1, amp);
        for (int i = 0; i < 2; i++) begin
            sdir = 1'(i);
            req = 1'b1;
            w(1);
            req = 1'b0;
            chk("step", 1, so);
            chk("dir", i, dout);
            w(4);
        end
        idx[0] = 1'b1;
        w(8);
        chk("index", 1, iseen[0]);
        results();
    end
endmodule
`default_nettype wire
